// *** ttl_pkg.sv ***
package ttl_pkg;

  // Register map
  localparam logic [7:0] ADDR_TRIP_PROG    = 8'h14;
  localparam logic [7:0] ADDR_TRIP_FIXED   = 8'h18;
  localparam logic [7:0] ADDR_FAN_DRIVE    = 8'h19;
  localparam logic [7:0] ADDR_REM_VALUE    = 8'h26;
  localparam logic [7:0] ADDR_INT_VALUE    = 8'h27;
  localparam logic [7:0] ADDR_REM_HIGH     = 8'h37;
  localparam logic [7:0] ADDR_REM_LOW      = 8'h38;
  localparam logic [7:0] ADDR_INT_HIGH     = 8'h39;
  localparam logic [7:0] ADDR_INT_LOW      = 8'h3a;
  localparam logic [7:0] ADDR_MAKER_ID     = 8'h3e;
  localparam logic [7:0] ADDR_REVISION     = 8'h3f;
  localparam logic [7:0] ADDR_CONFIG       = 8'h40;
  localparam logic [7:0] ADDR_FLAGS        = 8'h41;
  localparam logic [7:0] ADDR_GATING       = 8'h43;
  localparam logic [7:0] ADDR_REMOTE_FUNC  = 8'h4b;
  localparam logic [7:0] ADDR_ALERT_FLAGS  = 8'h4c;

  // Reset values and forced fan level
  localparam logic [7:0] CONFIG_RST        = 8'h21;
  localparam logic [7:0] FLAGS_RST         = 8'h00;
  localparam logic [7:0] GATING_RST        = 8'h00;
  localparam logic [7:0] REMOTE_FUNC_RST   = 8'h00;
  localparam logic [7:0] ALERT_FLAGS_VAL   = 8'h00;
  localparam logic [7:0] FAN_DRIVE_RST     = 8'h00;
  localparam logic [7:0] TRIP_DEFAULT      = 8'h64;
  localparam logic [7:0] FAN_FULL_SCALE    = 8'hff;

  // Configuration bits
  localparam int CFG_START    = 0;
  localparam int CFG_INT_EN   = 1;
  localparam int CFG_LOCK     = 3;
  localparam int CFG_SOFT_RST = 4;
  localparam int CFG_GPI_POL  = 6;

  // Flag bits
  localparam int FLG_INT_TEMP = 0;
  localparam int FLG_REM_TEMP = 1;
  localparam int FLG_SW       = 2;
  localparam int FLG_TRIP     = 3;
  localparam int FLG_GPI      = 4;

  // Remote function bits
  localparam int RFN_FAN_OFF  = 0;

  // Revision fields
  localparam int REV_STEP_LSB = 0;
  localparam int REV_VER_LSB  = 4;

  // Measurement qualification
  localparam int unsigned RUN_LEN = 3;
  localparam int          RUN_W   = 2;
  localparam logic signed [8:0] TRIP_HYST = 9'sh005;
  localparam int NUM_SENSORS  = 2;
  localparam int SENSOR_INT   = 0;
  localparam int SENSOR_REM   = 1;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ttl_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic       sensor;
    logic [7:0] value;
  } ttl_meas_t;

endpackage

// *** ttl_run_count.sv ***
// Counts an uninterrupted run of qualifying measurements
module ttl_run_count
  import ttl_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic restart,
  input  wire logic step,
  input  wire logic hit,
  output logic      run_done
);

  logic [RUN_W-1:0] count_r;
  localparam logic [RUN_W-1:0] LAST = RUN_W'(RUN_LEN - 1);
  localparam logic [RUN_W-1:0] FULL = RUN_W'(RUN_LEN);

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      count_r <= '0;
    end else if (step) begin
      if (!hit) begin
        count_r <= '0;
      end else if (count_r != FULL) begin
        count_r <= count_r + RUN_W'(1);
      end
    end
  end

  // High in the step that completes (or extends) a full run
  assign run_done = step && hit && (count_r >= LAST);

endmodule

// *** ttl_thermal_trip.sv ***
module ttl_thermal_trip
  import ttl_pkg::*;
#(
  parameter logic [7:0] MAKER_ID  = 8'h5a,
  parameter logic [3:0] STEPPING  = 4'h0,
  parameter logic [3:0] VERSION   = 4'h1
)
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         auxiliary_reset_n,
  input  wire logic         host_reset_n,
  input  wire logic         general_input_pin,
  input  wire logic         fan_drive_test_strap,
  input  wire logic         sda_in,
  input  wire logic         scl_in,
  input  wire ttl_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire ttl_meas_t    meas,
  output logic              conv_enable,
  output logic [7:0]        fan_drive_level,
  output logic              fan_gate_n,
  output logic              trip_a_or_tree_out,
  output logic              trip_a_oe,
  output logic              trip_out_b,
  output logic              trip_b_oe,
  output logic              int_n_out,
  output logic              int_n_oe,
  output logic              test_mode
);

  logic [7:0] config_r;
  logic [7:0] flags_r;
  logic [7:0] gating_r;
  logic [7:0] remote_func_r;
  logic [7:0] fan_r;
  logic [7:0] trip_prog_r;
  logic [7:0] value_r [NUM_SENSORS];
  logic [7:0] high_r  [NUM_SENSORS];
  logic [7:0] low_r   [NUM_SENSORS];
  logic [NUM_SENSORS-1:0] armed_r;
  logic       trip_r;
  logic       sw_int_r;
  logic       strap_done_r;
  logic       test_mode_r;
  logic       tree_r;
  logic       int_out_r;

  logic       soft_rst;
  logic       init;
  logic       meas_take;
  logic       gpi_level;
  logic [7:0] trip_limit;
  logic [NUM_SENSORS-1:0] out_now;
  logic [NUM_SENSORS-1:0] out_done;
  logic [NUM_SENSORS-1:0] in_done;
  logic       trip_over;
  logic       trip_under;
  logic       trip_set_done;
  logic       trip_rel_done;
  logic       tree_nxt;

  function automatic logic wr_to(input ttl_reg_req_t r, input logic [7:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction

  assign soft_rst = wr_to(reg_req, ADDR_CONFIG) && reg_req.wdata[CFG_SOFT_RST];
  assign init = rst || !auxiliary_reset_n || soft_rst;

  assign conv_enable = config_r[CFG_START] && auxiliary_reset_n && !test_mode_r && !rst;
  assign meas_take   = meas.valid && conv_enable;

  assign gpi_level = general_input_pin ^ config_r[CFG_GPI_POL];

  always_ff @(posedge clock) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      test_mode_r  <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      test_mode_r  <= fan_drive_test_strap;
    end
  end
  assign test_mode = test_mode_r;

  // Configuration register
  always_ff @(posedge clock) begin
    if (init) begin
      config_r <= CONFIG_RST;
    end else if (wr_to(reg_req, ADDR_CONFIG)) begin
      config_r <= {reg_req.wdata[7:CFG_LOCK+1],
                   reg_req.wdata[CFG_LOCK] | config_r[CFG_LOCK],
                   reg_req.wdata[CFG_LOCK-1:0]};
      if (!host_reset_n) begin
        config_r[CFG_LOCK] <= 1'b0;
      end
    end else if (!host_reset_n) begin
      config_r[CFG_LOCK] <= 1'b0;
    end
  end

  // Gating and remote function registers
  always_ff @(posedge clock) begin
    if (init) begin
      gating_r      <= GATING_RST;
      remote_func_r <= REMOTE_FUNC_RST;
    end else begin
      if (wr_to(reg_req, ADDR_GATING)) begin
        gating_r <= reg_req.wdata;
      end
      if (wr_to(reg_req, ADDR_REMOTE_FUNC)) begin
        remote_func_r <= reg_req.wdata;
      end
    end
  end

  // Fan drive register keeps software writes even while forced
  always_ff @(posedge clock) begin
    if (init || !host_reset_n) begin
      fan_r <= FAN_DRIVE_RST;
    end else if (wr_to(reg_req, ADDR_FAN_DRIVE)) begin
      fan_r <= reg_req.wdata;
    end
  end

  // Programmable trip limit
  always_ff @(posedge clock) begin
    if (init) begin
      trip_prog_r <= TRIP_DEFAULT;
    end else if (wr_to(reg_req, ADDR_TRIP_PROG) && !config_r[CFG_LOCK]) begin
      trip_prog_r <= reg_req.wdata;
    end
  end

  // Limits and values: no reset, untouched by soft reset
  always_ff @(posedge clock) begin
    if (wr_to(reg_req, ADDR_INT_HIGH)) high_r[SENSOR_INT] <= reg_req.wdata;
    if (wr_to(reg_req, ADDR_INT_LOW))  low_r[SENSOR_INT]  <= reg_req.wdata;
    if (wr_to(reg_req, ADDR_REM_HIGH)) high_r[SENSOR_REM] <= reg_req.wdata;
    if (wr_to(reg_req, ADDR_REM_LOW))  low_r[SENSOR_REM]  <= reg_req.wdata;
    if (meas_take) begin
      value_r[meas.sensor] <= meas.value;
    end
  end

  // Per-sensor limit qualification
  for (genvar s = 0; s < NUM_SENSORS; s++) begin : g_sensor
    logic this_step;
    assign this_step = meas_take && (meas.sensor == 1'(s));
    assign out_now[s] = ($signed(meas.value) > $signed(high_r[s])) ||
                        ($signed(meas.value) < $signed(low_r[s]));
    ttl_run_count u_out (
      .clock    (clock),
      .rst      (rst),
      .restart  (init),
      .step     (this_step),
      .hit      (out_now[s]),
      .run_done (out_done[s])
    );
    ttl_run_count u_in (
      .clock    (clock),
      .rst      (rst),
      .restart  (init),
      .step     (this_step),
      .hit      (!out_now[s]),
      .run_done (in_done[s])
    );
  end

  // Arming: cleared when a flag is set, restored after an in-limit run
  always_ff @(posedge clock) begin
    if (init) begin
      armed_r <= '1;
    end else begin
      for (int s = 0; s < NUM_SENSORS; s++) begin
        if (out_done[s] && armed_r[s]) begin
          armed_r[s] <= 1'b0;
        end else if (in_done[s]) begin
          armed_r[s] <= 1'b1;
        end
      end
    end
  end

  assign trip_limit = config_r[CFG_LOCK] ? trip_prog_r : TRIP_DEFAULT;
  assign trip_over  = $signed(meas.value) > $signed(trip_limit);
  assign trip_under = $signed({meas.value[7], meas.value}) <=
                      ($signed({trip_limit[7], trip_limit}) - TRIP_HYST);

  ttl_run_count u_trip_set (
    .clock    (clock),
    .rst      (rst),
    .restart  (init || trip_r),
    .step     (meas_take && meas.sensor == SENSOR_REM[0]),
    .hit      (trip_over),
    .run_done (trip_set_done)
  );

  ttl_run_count u_trip_rel (
    .clock    (clock),
    .rst      (rst),
    .restart  (init || !trip_r),
    .step     (meas_take && meas.sensor == SENSOR_REM[0]),
    .hit      (trip_under),
    .run_done (trip_rel_done)
  );

  always_ff @(posedge clock) begin
    if (init) begin
      trip_r <= 1'b0;
    end else if (!trip_r && trip_set_done) begin
      trip_r <= 1'b1;
    end else if (trip_r && trip_rel_done) begin
      trip_r <= 1'b0;
    end
  end

  // Flags: hardware set wins over write-one clear
  always_ff @(posedge clock) begin
    if (init) begin
      flags_r <= FLAGS_RST;
    end else begin
      if (wr_to(reg_req, ADDR_FLAGS)) begin
        flags_r <= flags_r & ~reg_req.wdata;
      end
      for (int s = 0; s < NUM_SENSORS; s++) begin
        if (meas_take && meas.sensor == 1'(s)) begin
          if (out_done[s] && armed_r[s]) begin
            flags_r[s] <= 1'b1;
          end else if (!out_now[s]) begin
            flags_r[s] <= 1'b0;
          end
        end
      end
      if (!trip_r && trip_set_done) begin
        flags_r[FLG_TRIP] <= 1'b1;
      end
      flags_r[FLG_GPI] <= gpi_level;
    end
  end

  // Software interrupt stands until interrupt enable is cleared
  always_ff @(posedge clock) begin
    if (init || !config_r[CFG_INT_EN]) begin
      sw_int_r <= 1'b0;
    end else if (wr_to(reg_req, ADDR_FLAGS) &&
                 (reg_req.wdata[FLG_REM_TEMP] || reg_req.wdata[FLG_SW])) begin
      sw_int_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (init) begin
      int_out_r <= 1'b0;
    end else begin
      int_out_r <= (|(flags_r & ~gating_r)) || sw_int_r || trip_r;
    end
  end

  assign tree_nxt = ~(scl_in & ~(sda_in & ~(general_input_pin &
                    ~(auxiliary_reset_n & ~host_reset_n))));

  always_ff @(posedge clock) begin
    if (rst) begin
      tree_r <= 1'b1;
    end else begin
      tree_r <= tree_nxt;
    end
  end

  // Open-drain pins: value low, enable while pulling; in test mode trip A drives the tree value
  assign trip_a_or_tree_out = test_mode_r ? tree_r : 1'b0;
  assign trip_a_oe          = test_mode_r ? 1'b1 : trip_r;
  assign trip_out_b         = 1'b0;
  assign trip_b_oe          = trip_r && !test_mode_r;
  assign int_n_out          = 1'b0;
  assign int_n_oe           = int_out_r && config_r[CFG_INT_EN] && !test_mode_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      fan_drive_level <= FAN_DRIVE_RST;
      fan_gate_n      <= 1'b1;
    end else begin
      fan_drive_level <= trip_r ? FAN_FULL_SCALE : fan_r;
      fan_gate_n      <= trip_r || !remote_func_r[RFN_FAN_OFF];
    end
  end

  // Read data, one cycle after the address
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      case (reg_req.addr)
        ADDR_TRIP_PROG:   reg_rdata <= trip_prog_r;
        ADDR_TRIP_FIXED:  reg_rdata <= TRIP_DEFAULT;
        ADDR_FAN_DRIVE:   reg_rdata <= fan_r;
        ADDR_REM_VALUE:   reg_rdata <= value_r[SENSOR_REM];
        ADDR_INT_VALUE:   reg_rdata <= value_r[SENSOR_INT];
        ADDR_REM_HIGH:    reg_rdata <= high_r[SENSOR_REM];
        ADDR_REM_LOW:     reg_rdata <= low_r[SENSOR_REM];
        ADDR_INT_HIGH:    reg_rdata <= high_r[SENSOR_INT];
        ADDR_INT_LOW:     reg_rdata <= low_r[SENSOR_INT];
        // Identity value is arbitrary
        ADDR_MAKER_ID:    reg_rdata <= MAKER_ID;
        ADDR_REVISION:    reg_rdata <= {VERSION, STEPPING};
        ADDR_CONFIG:      reg_rdata <= config_r;
        ADDR_FLAGS:       reg_rdata <= flags_r;
        ADDR_GATING:      reg_rdata <= gating_r;
        ADDR_REMOTE_FUNC: reg_rdata <= remote_func_r;
        ADDR_ALERT_FLAGS: reg_rdata <= ALERT_FLAGS_VAL;
        default:          reg_rdata <= '0;
      endcase
    end
  end

endmodule

// *** ttl_host_model.sv ***
module ttl_host_model
  import ttl_pkg::*;
(
  input  wire logic [7:0] reg_rdata,
  input  wire logic       clock,
  output ttl_reg_req_t    reg_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, addr: a, wdata: v};
    @(posedge clock);
    reg_req <= '{wr: 1'b0, addr: a, wdata: ~v};
  endtask

  // Data taken at the edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1;
    v = reg_rdata;
  endtask
endmodule

// *** ttl_thermal_trip_assertions.sv ***
module ttl_thermal_trip_checker
  import ttl_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       auxiliary_reset_n,
  input wire logic       fan_drive_test_strap,
  input wire ttl_meas_t  meas,
  input wire logic       conv_enable,
  input wire logic [7:0] fan_drive_level,
  input wire logic       fan_gate_n,
  input wire logic       trip_a_oe,
  input wire logic       trip_out_b,
  input wire logic       trip_b_oe,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  input wire logic       test_mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_fan_forced: assert property (trip_b_oe |=> fan_drive_level == FAN_FULL_SCALE)
    else $error("fan drive not full scale while tripped");
  a_gate_negated: assert property (trip_b_oe |=> fan_gate_n)
    else $error("fan gate active while tripped");
  a_trips_together: assert property (!test_mode |-> trip_a_oe == trip_b_oe)
    else $error("trip outputs disagree");
  a_trip_low: assert property (trip_b_oe |-> !trip_out_b)
    else $error("trip b driven high");
  a_trip_cause: assert property ($rose(trip_b_oe) |->
    $past(meas.valid) && $past(meas.sensor) && $past(conv_enable))
    else $error("trip rose without a remote reading");
  a_int_low: assert property (int_n_oe |-> !int_n_out)
    else $error("interrupt driven high");
  a_conv_stop: assert property (!auxiliary_reset_n || test_mode |-> !conv_enable)
    else $error("converter enabled during aux reset or test");
  a_tree_drive: assert property (test_mode |-> trip_a_oe && !trip_b_oe)
    else $error("tree output not driven in test mode");
  a_test_sticky: assert property (test_mode |=> test_mode)
    else $error("test mode left");
  a_strap_latch: assert property ($past(rst) |=> test_mode == $past(fan_drive_test_strap))
    else $error("strap not latched after reset");

  c_trip: cover property ($rose(trip_b_oe));
  c_int: cover property ($rose(int_n_oe));
  c_test: cover property ($rose(test_mode));
endmodule

bind ttl_thermal_trip ttl_thermal_trip_checker i_ttl_thermal_trip_checker (
  .clock, .rst, .auxiliary_reset_n, .fan_drive_test_strap, .meas, .conv_enable,
  .fan_drive_level, .fan_gate_n, .trip_a_oe, .trip_out_b, .trip_b_oe, .int_n_out,
  .int_n_oe, .test_mode
);

// *** tb.sv ***
module tb
  import ttl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clock, rst, auxiliary_reset_n, host_reset_n, general_input_pin;
  logic         fan_drive_test_strap, sda_in, scl_in, conv_enable, fan_gate_n;
  logic         trip_a_or_tree_out, trip_a_oe, trip_out_b, trip_b_oe, int_n_out, int_n_oe;
  logic         test_mode;
  logic [7:0]   reg_rdata, fan_drive_level, d;
  ttl_reg_req_t reg_req;
  ttl_meas_t    meas;
  int           miscompares, samples_checked;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Identity values are arbitrary
  ttl_thermal_trip #(.MAKER_ID(8'h3c), .STEPPING(4'h2), .VERSION(4'h7)) i_ttl_thermal_trip (
    .clock, .rst, .auxiliary_reset_n, .host_reset_n, .general_input_pin,
    .fan_drive_test_strap, .sda_in, .scl_in, .reg_req, .reg_rdata, .meas, .conv_enable,
    .fan_drive_level, .fan_gate_n, .trip_a_or_tree_out, .trip_a_oe, .trip_out_b,
    .trip_b_oe, .int_n_out, .int_n_oe, .test_mode
  );

  ttl_host_model i_ttl_host_model (.clock, .reg_rdata, .reg_req);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_ttl_host_model.wr(a, v);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_ttl_host_model.rd(a, d);
    chk(d, e);
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic ms(input logic s, input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge clock);
      meas <= '{valid: 1'b1, sensor: s, value: v};
      @(posedge clock);
      meas.valid <= 1'b0;
    end
    settle();
  endtask

  task automatic t_defaults();
    logic [7:0] a [11] = '{ADDR_CONFIG, ADDR_FLAGS, ADDR_GATING, ADDR_REMOTE_FUNC,
      ADDR_ALERT_FLAGS, ADDR_FAN_DRIVE, ADDR_TRIP_PROG, ADDR_TRIP_FIXED, ADDR_REVISION,
      ADDR_MAKER_ID, 8'h50};
    logic [7:0] e [11] = '{CONFIG_RST, FLAGS_RST, GATING_RST, REMOTE_FUNC_RST,
      ALERT_FLAGS_VAL, FAN_DRIVE_RST, TRIP_DEFAULT, TRIP_DEFAULT, 8'h72, 8'h3c, 8'h00};
    for (int i = 0; i < 11; i++) begin
      rchk(a[i], e[i]);
    end
    wr(ADDR_REVISION, 8'h00);
    rchk(ADDR_REVISION, 8'h72);
    wr(ADDR_REM_HIGH, 8'h7f);
    wr(ADDR_REM_LOW, 8'h80);
    wr(ADDR_INT_HIGH, 8'h30);
    wr(ADDR_INT_LOW, 8'h00);
  endtask

  task automatic t_int();
    wr(ADDR_CONFIG, 8'h23);
    ms(1'b0, 8'h40, 2);
    rchk(ADDR_FLAGS, 8'h00);
    ms(1'b0, 8'h40, 1);
    rchk(ADDR_FLAGS, 8'h01);
    chk(8'(int_n_oe), 8'h01);
    wr(ADDR_GATING, 8'h01);
    settle();
    chk(8'(int_n_oe), 8'h00);
    rchk(ADDR_FLAGS, 8'h01);
    wr(ADDR_GATING, 8'h00);
    wr(ADDR_FLAGS, 8'h01);
    settle();
    chk(8'(int_n_oe), 8'h00);
    ms(1'b0, 8'h40, 3);
    rchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_FLAGS, 8'h04);
    settle();
    chk(8'(int_n_oe), 8'h01);
    wr(ADDR_CONFIG, 8'h21);
    settle();
    chk(8'(int_n_oe), 8'h00);
    wr(ADDR_CONFIG, 8'h10);
    rchk(ADDR_CONFIG, CONFIG_RST);
    rchk(ADDR_INT_HIGH, 8'h30);
    wr(ADDR_CONFIG, 8'h23);
    ms(1'b0, 8'h40, 3);
    rchk(ADDR_FLAGS, 8'h01);
    ms(1'b0, 8'h10, 3);
    rchk(ADDR_FLAGS, 8'h00);
    ms(1'b0, 8'h40, 3);
    rchk(ADDR_FLAGS, 8'h01);
    wr(ADDR_FLAGS, 8'h01);
  endtask

  task automatic t_gpi();
    @(posedge clock);
    general_input_pin <= 1'b1;
    rchk(ADDR_FLAGS, 8'h10);
    wr(ADDR_FLAGS, 8'h10);
    rchk(ADDR_FLAGS, 8'h10);
    chk(8'(int_n_oe), 8'h01);
    wr(ADDR_CONFIG, 8'h63);
    rchk(ADDR_FLAGS, 8'h00);
    @(posedge clock);
    general_input_pin <= 1'b0;
    rchk(ADDR_FLAGS, 8'h10);
    wr(ADDR_CONFIG, 8'h23);
  endtask

  task automatic t_trip();
    wr(ADDR_FAN_DRIVE, 8'h33);
    wr(ADDR_REMOTE_FUNC, 8'h01);
    ms(1'b1, 8'h70, 2);
    ms(1'b1, 8'h10, 1);
    ms(1'b1, 8'h70, 2);
    chk(8'(trip_b_oe), 8'h00);
    chk(8'(fan_gate_n), 8'h00);
    ms(1'b1, 8'h70, 1);
    chk(8'(trip_b_oe), 8'h01);
    chk(8'(trip_a_oe), 8'h01);
    chk(fan_drive_level, FAN_FULL_SCALE);
    chk(8'(fan_gate_n), 8'h01);
    rchk(ADDR_FLAGS, 8'h08);
    wr(ADDR_FAN_DRIVE, 8'h44);
    ms(1'b1, 8'h60, 3);
    chk(fan_drive_level, FAN_FULL_SCALE);
    ms(1'b1, 8'h5f, 3);
    chk(8'(trip_b_oe), 8'h00);
    chk(fan_drive_level, 8'h44);
  endtask

  task automatic t_lock();
    wr(ADDR_TRIP_PROG, 8'h40);
    wr(ADDR_CONFIG, 8'h2b);
    wr(ADDR_TRIP_PROG, 8'h50);
    rchk(ADDR_TRIP_PROG, 8'h40);
    wr(ADDR_CONFIG, 8'h23);
    rchk(ADDR_CONFIG, 8'h2b);
    ms(1'b1, 8'h48, 3);
    chk(8'(trip_b_oe), 8'h01);
    ms(1'b1, 8'h10, 3);
    wr(ADDR_FAN_DRIVE, 8'h55);
    @(posedge clock);
    host_reset_n <= 1'b0;
    @(posedge clock);
    host_reset_n <= 1'b1;
    rchk(ADDR_CONFIG, 8'h23);
    rchk(ADDR_FAN_DRIVE, 8'h00);
    rchk(ADDR_TRIP_PROG, 8'h40);
  endtask

  task automatic t_aux();
    wr(ADDR_GATING, 8'h0f);
    @(posedge clock);
    auxiliary_reset_n <= 1'b0;
    rchk(ADDR_GATING, GATING_RST);
    chk(8'(conv_enable), 8'h00);
    @(posedge clock);
    auxiliary_reset_n <= 1'b1;
    rchk(ADDR_CONFIG, CONFIG_RST);
  endtask

  task automatic t_tree();
    logic [4:0] tv [6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
    @(posedge clock);
    rst <= 1'b1;
    fan_drive_test_strap <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    settle();
    chk(8'(test_mode), 8'h01);
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      {host_reset_n, auxiliary_reset_n, general_input_pin, sda_in, scl_in} <= tv[k];
      settle();
      chk(8'(trip_a_or_tree_out), (k % 2 == 0) ? 8'h01 : 8'h00);
    end
  endtask

  task automatic summarize();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end

  initial begin
    {rst, auxiliary_reset_n, host_reset_n, general_input_pin} = 4'b1110;
    {fan_drive_test_strap, sda_in, scl_in} = 3'b011;
    meas = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_defaults();
    t_int();
    t_gpi();
    t_trip();
    t_lock();
    t_aux();
    t_tree();
    summarize();
  end
endmodule
